// File: dv/ipn_ext_model.sv
// External requester model: drives encoded or dedicated request pins
`default_nettype none
module ipn_ext_model (
  // Bench control, level 0 means no request
  input  wire logic       mode_in,
  input  wire logic [2:0] level_in,
  // Request pins
  output logic      [2:0] encoded_n_out,
  output logic            req7_out,
  output logic            req6_out,
  output logic            req1_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // Idle code 111 reads as no request; level 4 is never put on the pins
  always_comb begin
    encoded_n_out = 3'h7;
    if (!mode_in && level_in != 3'h4) begin
      encoded_n_out = ~level_in;
    end
  end
  // Held until the bench drops the level, as a real device would
  assign req7_out = mode_in && level_in == 3'h7;
  assign req6_out = mode_in && level_in == 3'h6;
  assign req1_out = mode_in && level_in == 3'h1;
endmodule
`default_nettype wire

// File: dv/tb_ipn_ctrl.sv
// Self-checking bench for the interrupt priority and nesting controller
`default_nettype none
module tb_ipn_ctrl;
  import ipn_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================================
  // Signals
  logic        clk_in = 1'b0;
  logic        srst_in = 1'b1;
  logic        ce = 1'h1;
  logic [2:0]  core_mask = 3'h0;
  logic        mode = 1'b0;
  logic        ack_valid = 1'b0;
  logic [2:0]  ack_level = 3'h0;
  logic [2:0]  ext_level = 3'h0;
  ipn_vec_type evt = '0;
  ipn_vec_type evt_clr = '0;
  ipn_vec_type mask = '0;
  ipn_vec_type is_clr = '0;
  logic [2:0]  enc_n;
  logic        req7;
  logic        req6;
  logic        req1;
  logic [2:0]  core_level;
  logic [4:0]  vec;
  logic        vec_valid;
  ipn_vec_type pend;
  ipn_vec_type insvc;
  int          mismatches = 0;
  int          n_compared = 0;
  logic [2:0]  lv[6] = '{3'h7, 3'h6, 3'h5, 3'h3, 3'h2, 3'h1};
  logic [2:0]  dl[3] = '{3'h7, 3'h6, 3'h1};
  logic [4:0]  dv[3] = '{5'h17, 5'h16, 5'h11};
  always #25 clk_in = ~clk_in;
  // ==========================================================
  // Instances
  ipn_ext_model u_ipn_ext_model (.mode_in(mode), .level_in(ext_level),
    .encoded_n_out(enc_n), .req7_out(req7), .req6_out(req6), .req1_out(req1));
  ipn_ctrl u_ipn_ctrl (.clk_in(clk_in), .srst_in(srst_in), .ce_in(ce),
    .pin_mode_select_in(mode), .encoded_priority_inputs_n_in(enc_n),
    .dedicated_request_level7_in(req7), .dedicated_request_level6_in(req6),
    .dedicated_request_level1_in(req1), .internal_event_in(evt),
    .event_clear_in(evt_clr), .source_mask_register_in(mask),
    .in_service_clear_in(is_clr), .ack_valid_in(ack_valid),
    .ack_level_in(ack_level), .core_level_out(core_level), .ack_vector_out(vec),
    .ack_vector_valid_out(vec_valid), .pending_register_out(pend),
    .in_service_register_out(insvc));
  // ==========================================================
  // Tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
      mismatches++;
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
    #5;
  endtask
  task automatic ack(input logic [2:0] lvl);
    // Core takes a level above its mask, and level 7 always
    if (lvl > core_mask || lvl == 3'h7) begin
      ack_valid = 1'h1;
    end
    ack_level = lvl;
    tick(1);
    ack_valid = 1'b0;
  endtask
  task automatic clear_service();
    is_clr = '1;
    tick(1);
    is_clr = '0;
    tick(1);
  endtask
  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // ==========================================================
  // Tests
  initial begin
    tick(6);
    srst_in = 1'b0;
    check(core_level, 3'h0);
    check({vec_valid, pend, insvc}, '0);
    evt[12] = 1'b1;
    evt[5] = 1'b1;
    tick(1);
    evt = '0;
    tick(1);
    check(core_level, 3'h4);
    ack(3'h4);
    check({vec_valid, vec}, {1'b1, 5'h0D});
    check(pend, 15'h0020);
    check(insvc, 15'h1000);
    evt[3] = 1'b1;
    tick(1);
    evt = '0;
    tick(1);
    check(core_level, 3'h0);
    check(pend, 15'h0028);
    evt[14] = 1'b1;
    tick(1);
    evt = '0;
    tick(1);
    check(core_level, 3'h4);
    core_mask = 3'h3;
    ack(3'h4);
    check({vec_valid, vec}, {1'b1, 5'h0F});
    clear_service();
    check(core_level, 3'h4);
    ack(3'h4);
    check(vec, 5'h06);
    clear_service();
    ack(3'h4);
    check(vec, 5'h04);
    clear_service();
    core_mask = 3'h0;
    $display("test ranking and nesting done");
    mask = '1;
    evt[2] = 1'b1;
    tick(1);
    evt = '0;
    tick(1);
    check(pend, 15'h0004);
    check(core_level, 3'h0);
    evt_clr[2] = 1'b1;
    tick(1);
    evt_clr = '0;
    check(pend, 15'h0000);
    mask = '0;
    ack(3'h4);
    check({vec_valid, vec, insvc}, {1'b1, 5'h00, 15'h0000});
    tick(1);
    ack(3'h5);
    check(vec_valid, 1'b0);
    $display("test masking and error vector done");
    foreach (lv[i]) begin
      ext_level = lv[i];
      tick(1);
      check(core_level, lv[i]);
    end
    ce = 1'h0;
    ext_level = 3'h6;
    tick(2);
    check(core_level, 3'h1);
    ce = 1'h1;
    tick(1);
    check(core_level, 3'h6);
    evt[0] = 1'b1;
    ext_level = 3'h3;
    tick(1);
    evt = '0;
    tick(1);
    check(core_level, 3'h4);
    ext_level = 3'h7;
    tick(1);
    check(core_level, 3'h7);
    ack(3'h7);
    check({vec_valid, vec, pend}, {1'b1, 5'h17, 15'h0001});
    ext_level = 3'h0;
    tick(1);
    ack(3'h4);
    check(vec, 5'h01);
    clear_service();
    $display("test normal mode done");
    mode = 1'b1;
    foreach (dl[i]) begin
      ext_level = dl[i];
      tick(1);
      check(core_level, dl[i]);
      ack(dl[i]);
      check({vec_valid, vec}, {1'b1, dv[i]});
      ext_level = 3'h0;
      tick(1);
    end
    ext_level = 3'h5;
    tick(2);
    check(core_level, 3'h0);
    $display("test dedicated mode done");
    give_verdict();
  end
  // Run needs about 60 cycles; far more means a hang
  initial begin
    #(5000 * 50);
    mismatches++;
    give_verdict();
  end
endmodule
`default_nettype wire

// File: hw/ipn_ctrl.sv
// Interrupt priority and nesting controller
`default_nettype none
`include "ipn_cfg.svh"
module ipn_ctrl
  import ipn_pkg::*;
#(
  parameter int NSRC = `IPN_NSRC
) (
  // Clock, reset, enable
  input  wire logic              clk_in,
  input  wire logic              srst_in,
  input  wire logic              ce_in,
  // Mode and external request pins
  input  wire logic              pin_mode_select_in,
  input  wire logic [2:0]        encoded_priority_inputs_n_in,
  input  wire logic              dedicated_request_level7_in,
  input  wire logic              dedicated_request_level6_in,
  input  wire logic              dedicated_request_level1_in,
  // Internal source events (already gated by peripheral event masks)
  input  wire logic [NSRC-1:0]   internal_event_in,
  input  wire logic [NSRC-1:0]   event_clear_in,
  // Software control
  input  wire logic [NSRC-1:0]   source_mask_register_in,
  input  wire logic [NSRC-1:0]   in_service_clear_in,
  // Acknowledge cycle from the core
  input  wire logic              ack_valid_in,
  input  wire logic [2:0]        ack_level_in,
  // Request and status
  output var  logic [2:0]        core_level_out,
  output var  logic [4:0]        ack_vector_out,
  output var  logic              ack_vector_valid_out,
  output var  logic [NSRC-1:0]   pending_register_out,
  output var  logic [NSRC-1:0]   in_service_register_out
);
  typedef struct packed {
    logic [NSRC-1:0] in_service;
    logic [2:0]      level;
    logic [4:0]      vector;
    logic            vec_valid;
  } ipn_state_type;

  ipn_state_type   state_q;
  ipn_state_type   state_d;
  logic [NSRC-1:0] pending;
  logic [NSRC-1:0] ack_clear;
  logic [NSRC-1:0] eligible;
  logic [NSRC-1:0] block_mask;
  logic [2:0]      ext_level;
  logic [2:0]      int_level;
  logic [2:0]      top_level;
  logic            ack_int;
  int              win;

  // =========================================
  // Helpers
  // Highest set bit index, or -1 when none
  function automatic int top_bit(input logic [NSRC-1:0] v);
    int r;
    r = -1;
    for (int i = 0; i < NSRC; i++) begin
      if (v[i]) begin
        r = i;
      end
    end
    return r;
  endfunction

  // Vector code for internal source index: lowest source gives 00001
  function automatic logic [4:0] src_vector(input int idx);
    return 5'(idx + 1);
  endfunction

  // =========================================
  // Pending bits, one small cell per source
  for (genvar g = 0; g < NSRC; g++) begin : g_src
    ipn_src_pending u_pend (
      .clk_in         (clk_in),
      .srst_in        (srst_in),
      .ce_in          (ce_in),
      .event_in       (internal_event_in[g]),
      .event_clear_in (event_clear_in[g]),
      .ack_clear_in   (ack_clear[g]),
      .pending_out    (pending[g])
    );
  end

  // =========================================
  // External level decode
  always_comb begin
    ext_level = `IPN_LVL_NONE;
    if (pin_mode_select_in == `IPN_MODE_NORMAL) begin
      // Inputs are active low; level 4 code is never used externally
      ext_level = ~encoded_priority_inputs_n_in;
      if (ext_level == `IPN_INT_LEVEL) begin
        ext_level = `IPN_LVL_NONE;
      end
    end else if (dedicated_request_level7_in) begin
      ext_level = `IPN_NMI_LEVEL;
    end else if (dedicated_request_level6_in) begin
      ext_level = `IPN_LVL6;
    end else if (dedicated_request_level1_in) begin
      ext_level = `IPN_LVL1;
    end
  end

  // =========================================
  // Internal ranking with nesting
  always_comb begin
    block_mask = '0;
    // In-service source blocks itself and everything ranked below
    for (int i = 0; i < NSRC; i++) begin
      for (int j = 0; j <= i; j++) begin
        if (state_q.in_service[i]) begin
          block_mask[j] = 1'h1;
        end
      end
    end
    eligible = pending & ~source_mask_register_in & ~block_mask;
    win = top_bit(eligible);
    int_level = (win >= 0) ? `IPN_INT_LEVEL : `IPN_LVL_NONE;
    top_level = (ext_level > int_level) ? ext_level : int_level;
  end

  // =========================================
  // Acknowledge handling
  assign ack_int = ce_in && ack_valid_in && (ack_level_in == `IPN_INT_LEVEL);

  always_comb begin
    ack_clear = '0;
    if (ack_int && win >= 0) begin
      ack_clear[win] = 1'h1;
    end
  end

  always_comb begin
    state_d = state_q;
    // Software clear first so a same-cycle acknowledge set wins
    state_d.in_service = state_q.in_service & ~in_service_clear_in;
    state_d.level = top_level;
    state_d.vec_valid = 1'h0;
    if (ack_valid_in) begin
      state_d.vec_valid = 1'h1;
      case (ack_level_in)
        `IPN_INT_LEVEL: begin
          if (win >= 0) begin
            state_d.vector = src_vector(win);
            state_d.in_service[win] = 1'h1;
          end else begin
            state_d.vector = `IPN_VEC_ERROR;
          end
        end
        `IPN_NMI_LEVEL: begin
          state_d.vector = `IPN_VEC_EXT7;
        end
        `IPN_LVL6: begin
          state_d.vector = `IPN_VEC_EXT6;
        end
        `IPN_LVL1: begin
          state_d.vector = `IPN_VEC_EXT1;
        end
        default: begin
          // External levels without a vector code; external device supplies it
          state_d.vector    = `IPN_VEC_NONE;
          state_d.vec_valid = 1'h0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      state_q <= '0;
    end else if (ce_in) begin
      state_q <= state_d;
    end
  end

  assign core_level_out          = state_q.level;
  assign ack_vector_out          = state_q.vector;
  assign ack_vector_valid_out    = state_q.vec_valid;
  assign pending_register_out    = pending;
  assign in_service_register_out = state_q.in_service;

  // =========================================
  // Checks: pending and acknowledge
  ack_clears_pend_a: assert property (@(posedge clk_in) disable iff (srst_in)
    ack_int && win >= 0 && !internal_event_in[win] |=> !pending[$past(win)])
    else $error("acked source still pending");
  ack_sets_insvc_a: assert property (@(posedge clk_in) disable iff (srst_in)
    ack_int && win >= 0 |=> in_service_register_out[$past(win)])
    else $error("in-service bit not set");
  error_vector_a: assert property (@(posedge clk_in) disable iff (srst_in)
    ack_int && win < 0 |=> ack_vector_valid_out && ack_vector_out == `IPN_VEC_ERROR)
    else $error("missing error vector");
  event_sets_pend_a: assert property (@(posedge clk_in) disable iff (srst_in)
    ce_in && internal_event_in[0] |=> pending[0])
    else $error("event did not set pending");
  masked_pend_a: assert property (@(posedge clk_in) disable iff (srst_in)
    ce_in && internal_event_in[2] && source_mask_register_in[2] |=> pending[2])
    else $error("masked event lost its pending bit");
  evclr_a: assert property (@(posedge clk_in) disable iff (srst_in)
    ce_in && event_clear_in[2] && !internal_event_in[2] |=> !pending[2])
    else $error("event clear ignored");
  // Other levels must leave the in-service bits alone
  ack_other_a: assert property (@(posedge clk_in) disable iff (srst_in)
    ce_in && ack_valid_in && ack_level_in != `IPN_INT_LEVEL && in_service_clear_in == '0
    |=> $stable(in_service_register_out))
    else $error("non level 4 acknowledge changed in-service bits");
  ext7_vector_a: assert property (@(posedge clk_in) disable iff (srst_in)
    ce_in && ack_valid_in && ack_level_in == `IPN_NMI_LEVEL
    |=> ack_vector_valid_out && ack_vector_out == `IPN_VEC_EXT7)
    else $error("level 7 vector wrong");
  ext6_vector_a: assert property (@(posedge clk_in) disable iff (srst_in)
    ce_in && ack_valid_in && ack_level_in == `IPN_LVL6
    |=> ack_vector_valid_out && ack_vector_out == `IPN_VEC_EXT6)
    else $error("level 6 vector wrong");
  ext1_vector_a: assert property (@(posedge clk_in) disable iff (srst_in)
    ce_in && ack_valid_in && ack_level_in == `IPN_LVL1
    |=> ack_vector_valid_out && ack_vector_out == `IPN_VEC_EXT1)
    else $error("level 1 vector wrong");
  // A low enable must hold the level, pending, in-service and vector valid outputs, acknowledge or not
  freeze_hold_a: assert property (@(posedge clk_in) disable iff (srst_in)
    !ce_in |=> $stable(core_level_out) && $stable(pending_register_out)
      && $stable(in_service_register_out) && $stable(ack_vector_valid_out))
    else $error("state moved while enable low");

  // =========================================
  // Checks: ranking and nesting
  top_rank_a: assert property (@(posedge clk_in) disable iff (srst_in)
    ack_int && eligible[NSRC-1] |=> ack_vector_out == `IPN_VEC_PP11)
    else $error("top ranked source vector wrong");
  low_rank_a: assert property (@(posedge clk_in) disable iff (srst_in)
    ack_int && eligible[0] && $onehot(eligible) |=> ack_vector_out == `IPN_VEC_PP8)
    else $error("lowest ranked source vector wrong");
  insvc_block_a: assert property (@(posedge clk_in) disable iff (srst_in)
    in_service_register_out[NSRC-1] |-> eligible == '0)
    else $error("in-service did not block");
  self_block_a: assert property (@(posedge clk_in) disable iff (srst_in)
    in_service_register_out[0] |-> !eligible[0])
    else $error("in-service source not blocked");
  nest_allow_a: assert property (@(posedge clk_in) disable iff (srst_in)
    !in_service_register_out[NSRC-1] && pending[NSRC-1] && !source_mask_register_in[NSRC-1]
    |-> eligible[NSRC-1])
    else $error("higher source blocked by lower service");
  int_level_a: assert property (@(posedge clk_in) disable iff (srst_in)
    ce_in && eligible != '0 && ext_level < `IPN_INT_LEVEL |=> core_level_out == `IPN_INT_LEVEL)
    else $error("internal request not at level 4");
  masked_no_req_a: assert property (@(posedge clk_in) disable iff (srst_in)
    ce_in && source_mask_register_in == '1 && ext_level == `IPN_LVL_NONE
    |=> core_level_out == `IPN_LVL_NONE)
    else $error("masked source raised request");

  // =========================================
  // Checks: external levels
  enc_level_a: assert property (@(posedge clk_in) disable iff (srst_in)
    ce_in && pin_mode_select_in == `IPN_MODE_NORMAL && eligible == '0
    && ~encoded_priority_inputs_n_in != `IPN_INT_LEVEL
    |=> core_level_out == ~$past(encoded_priority_inputs_n_in))
    else $error("encoded level not presented");
  ext_over_int_a: assert property (@(posedge clk_in) disable iff (srst_in)
    ce_in && ext_level > `IPN_INT_LEVEL |=> core_level_out == $past(ext_level))
    else $error("higher external level not presented");
  ded_l7_a: assert property (@(posedge clk_in) disable iff (srst_in)
    ce_in && pin_mode_select_in && dedicated_request_level7_in
    |=> core_level_out == `IPN_NMI_LEVEL)
    else $error("dedicated level 7 not presented");
  ded_l6_a: assert property (@(posedge clk_in) disable iff (srst_in)
    ce_in && pin_mode_select_in && !dedicated_request_level7_in && dedicated_request_level6_in
    |=> core_level_out == `IPN_LVL6)
    else $error("dedicated level 6 not presented");
  ded_l1_a: assert property (@(posedge clk_in) disable iff (srst_in)
    ce_in && pin_mode_select_in && dedicated_request_level1_in && eligible == '0
    && !dedicated_request_level7_in && !dedicated_request_level6_in
    |=> core_level_out == `IPN_LVL1)
    else $error("dedicated level 1 not presented");

  // =========================================
  // Coverage of the main scenarios
  cov_nest_c: cover property (@(posedge clk_in)
    in_service_register_out[0] && core_level_out == `IPN_INT_LEVEL);
  cov_err_c: cover property (@(posedge clk_in) ack_int && win < 0);
  cov_ded_c: cover property (@(posedge clk_in)
    pin_mode_select_in && core_level_out == `IPN_LVL6);
  cov_poll_c: cover property (@(posedge clk_in)
    source_mask_register_in == '1 && pending_register_out != '0);
  cov_freeze_c: cover property (@(posedge clk_in) !ce_in && core_level_out != `IPN_LVL_NONE);
endmodule
`default_nettype wire

// File: hw/ipn_src_pending.sv
// Pending bit for one internal source, with event clear and acknowledge clear handling
`default_nettype none
`include "ipn_cfg.svh"
module ipn_src_pending
  import ipn_pkg::*;
(
  // Clock, reset, enable
  input  wire logic clk_in,
  input  wire logic srst_in,
  input  wire logic ce_in,
  // Event side
  input  wire logic event_in,
  input  wire logic event_clear_in,
  input  wire logic ack_clear_in,
  // Status
  output var  logic pending_out
);
  typedef struct packed {
    logic pend;
  } ipn_sp_state_type;

  ipn_sp_state_type state_q;
  ipn_sp_state_type state_d;

  // =========================================
  // Next state
  always_comb begin
    state_d = state_q;
    // New event wins over any clear in the same cycle
    if (ack_clear_in || event_clear_in) begin
      state_d.pend = 1'h0;
    end
    if (event_in) begin
      state_d.pend = 1'h1;
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      state_q <= '0;
    end else if (ce_in) begin
      state_q <= state_d;
    end
  end

  assign pending_out = state_q.pend;
endmodule
`default_nettype wire

// File: include/ipn_cfg.svh
// Constants for the interrupt priority and nesting block
`ifndef IPN_CFG_SVH
`define IPN_CFG_SVH
`define IPN_NSRC        15
`define IPN_INT_LEVEL   3'h4
`define IPN_NMI_LEVEL   3'h7
`define IPN_LVL6        3'h6
`define IPN_LVL1        3'h1
`define IPN_LVL_NONE    3'h0
`define IPN_VEC_ERROR   5'h00
`define IPN_VEC_EXT7    5'h17
`define IPN_VEC_EXT6    5'h16
`define IPN_VEC_EXT1    5'h11
`define IPN_VEC_PP11    5'h0F
`define IPN_VEC_PP8     5'h01
`define IPN_VEC_NONE    5'h00
`define IPN_MODE_NORMAL 1'h0
`define IPN_MODE_DEDIC  1'h1
`endif

// File: include/ipn_pkg.sv
// Types shared by the interrupt priority and nesting block
`default_nettype none
`include "ipn_cfg.svh"
package ipn_pkg;
  typedef logic [`IPN_NSRC-1:0] ipn_vec_type;
  // Source bit 14 is the highest ranked, bit 0 the lowest
  typedef struct packed {
    logic       valid;
    logic [2:0] level;
  } ipn_ack_type;
  typedef struct packed {
    logic [2:0] level;
    logic [4:0] vector;
    logic       vec_valid;
  } ipn_req_type;
endpackage
`default_nettype wire
